// >>> logic/cefr_pkg.sv
// constants for the charger event flag registers
package cefr_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] FLAGS_A_OFFSET = 8'h0f;
    localparam logic [7:0] FLAGS_B_OFFSET = 8'h10;
    localparam logic [7:0] FAULT_FLAGS_OFFSET = 8'h11;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    // field positions, flags a
    localparam int A_CONV_DONE_BIT = 7;
    localparam int A_INPUT_CURRENT_BIT = 6;
    localparam int A_INPUT_VOLTAGE_BIT = 5;
    localparam int A_DIE_TEMP_BIT = 4;
    localparam int A_WATCHDOG_BIT = 3;
    localparam int A_CHARGE_STATE_BIT = 0;
    // field positions, flags b
    localparam int B_POWER_GOOD_BIT = 7;
    localparam int B_SOURCE_BIT = 4;
    localparam int B_THERMISTOR_BIT = 2;
    localparam int B_OPTIMIZER_BIT = 1;
    localparam int B_MIN_SYS_BIT = 0;
    // field positions, fault flags
    localparam int F_INPUT_OV_BIT = 7;
    localparam int F_THERMAL_BIT = 6;
    localparam int F_BATTERY_OV_BIT = 5;
    localparam int F_TIMER_BIT = 4;
    localparam int F_OVERLOAD_BIT = 3;
    localparam int F_REVERSE_BIT = 0;
    // bits that exist in each register; the rest read zero
    localparam logic [7:0] FLAGS_A_USED = 8'hf9;
    localparam logic [7:0] FLAGS_B_USED = 8'h97;
    localparam logic [7:0] FAULT_FLAGS_USED = 8'hf9;
    localparam logic [7:0] MASK_A_RESET = 8'h00;
    localparam logic [7:0] MASK_B_RESET = 8'h00;
    localparam logic [7:0] MASK_F_RESET = 8'h00;
    // number of raw status bits
    localparam int STATUS_W = 25;
    // edges after reset until the edge detector compares two real samples
    localparam logic [1:0] FILL_DONE = 2'h3;
endpackage

// >>> logic/cefr_flags.sv
// event flag registers of a two-cell charger with read-clear and interrupt pulse
`timescale 1ns/1ps
module cefr_flags
    import cefr_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    // register port from the serial control interface
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // register-reset command, one-cycle pulse
    input wire logic reg_reset_cmd,
    // mask registers, held elsewhere
    input wire logic [7:0] mask_a,
    input wire logic [7:0] mask_b,
    input wire logic [7:0] mask_f,
    // internal status signals from analog or other clock regions
    input wire logic conv_done,
    input wire logic conv_continuous,
    input wire logic input_current_regulation,
    input wire logic input_voltage_regulation,
    input wire logic die_temp_regulation,
    input wire logic watchdog_expired_status,
    input wire logic [2:0] charge_state,
    input wire logic power_good,
    input wire logic [2:0] input_source_type,
    input wire logic [2:0] thermistor_zone,
    input wire logic [1:0] current_optimizer_state,
    input wire logic min_system_voltage,
    input wire logic input_overvoltage,
    input wire logic thermal_shutdown,
    input wire logic battery_overvoltage,
    input wire logic safety_timer_expired,
    input wire logic system_overload,
    input wire logic reverse_buck_fault,
    output logic int_pulse
);

    // two-stage synchroniser, then the sample one edge older for edge detection
    typedef struct packed {
        logic [STATUS_W-1:0] sync1;
        logic [STATUS_W-1:0] sync2;
        logic [STATUS_W-1:0] prev;
        // edges counted since reset, so that no false edge follows it
        logic [1:0] fill;
        logic [7:0] flags_a;
        logic [7:0] flags_b;
        logic [7:0] flags_f;
        logic [7:0] rdata;
        logic irq;
    } cefr_state_t;

    cefr_state_t st_reg;
    cefr_state_t st_next;

    // raw status levels, gathered into one vector for the synchroniser
    logic [STATUS_W-1:0] raw;
    assign raw = {
        conv_done,
        conv_continuous,
        input_current_regulation,
        input_voltage_regulation,
        die_temp_regulation,
        watchdog_expired_status,
        charge_state,
        power_good,
        input_source_type,
        thermistor_zone,
        current_optimizer_state,
        min_system_voltage,
        input_overvoltage,
        thermal_shutdown,
        battery_overvoltage,
        safety_timer_expired,
        system_overload,
        reverse_buck_fault
    };

    // unpacked view of the synchronised sample
    logic s_done;
    logic s_cont;
    logic s_icr;
    logic s_ivr;
    logic s_dtr;
    logic s_wd;
    logic [2:0] s_chg;
    logic s_pg;
    logic [2:0] s_src;
    logic [2:0] s_thm;
    logic [1:0] s_ico;
    logic s_msv;
    logic s_iov;
    logic s_tsd;
    logic s_bov;
    logic s_tmr;
    logic s_ovl;
    logic s_rev;
    // unpacked view of the sample one edge older
    logic p_done;
    logic p_cont;
    logic p_icr;
    logic p_ivr;
    logic p_dtr;
    logic p_wd;
    logic [2:0] p_chg;
    logic p_pg;
    logic [2:0] p_src;
    logic [2:0] p_thm;
    logic [1:0] p_ico;
    logic p_msv;
    logic p_iov;
    logic p_tsd;
    logic p_bov;
    logic p_tmr;
    logic p_ovl;
    logic p_rev;
    assign {
        s_done,
        s_cont,
        s_icr,
        s_ivr,
        s_dtr,
        s_wd,
        s_chg,
        s_pg,
        s_src,
        s_thm,
        s_ico,
        s_msv,
        s_iov,
        s_tsd,
        s_bov,
        s_tmr,
        s_ovl,
        s_rev
    } = st_reg.sync2;

    assign {
        p_done,
        p_cont,
        p_icr,
        p_ivr,
        p_dtr,
        p_wd,
        p_chg,
        p_pg,
        p_src,
        p_thm,
        p_ico,
        p_msv,
        p_iov,
        p_tsd,
        p_bov,
        p_tmr,
        p_ovl,
        p_rev
    } = st_reg.prev;

    // one strobe per event, before the pipeline-fill gate
    logic conversion_done_event;
    logic input_current_limit_event;
    logic input_voltage_limit_event;
    logic die_temp_regulation_event;
    logic watchdog_expiry_event;
    logic charge_state_event;
    logic power_good_event;
    logic input_source_change_event;
    logic thermistor_zone_event;
    logic current_optimizer_event;
    logic min_system_voltage_event;
    logic input_overvoltage_event;
    logic thermal_shutdown_event;
    logic battery_overvoltage_event;
    logic safety_timer_event;
    logic system_overload_event;
    logic reverse_buck_fault_event;

    // charger flags a
    assign conversion_done_event = s_done & ~p_done & ~s_cont;
    assign input_current_limit_event = s_icr & ~p_icr;
    assign input_voltage_limit_event = s_ivr & ~p_ivr;
    assign die_temp_regulation_event = s_dtr & ~p_dtr;
    assign watchdog_expiry_event = s_wd & ~p_wd;
    assign charge_state_event = s_chg != p_chg;

    // charger flags b
    assign power_good_event = s_pg ^ p_pg;
    assign input_source_change_event = s_src != p_src;
    assign thermistor_zone_event = s_thm != p_thm;
    assign current_optimizer_event = s_ico != p_ico;
    assign min_system_voltage_event = s_msv ^ p_msv;

    // fault flags
    assign input_overvoltage_event = s_iov & ~p_iov;
    assign thermal_shutdown_event = s_tsd & ~p_tsd;
    assign battery_overvoltage_event = s_bov & ~p_bov;
    assign safety_timer_event = s_tmr & ~p_tmr;
    assign system_overload_event = s_ovl & ~p_ovl;
    assign reverse_buck_fault_event = s_rev & ~p_rev;

    // events gathered per register at their bit positions
    logic [7:0] ev_a;
    logic [7:0] ev_b;
    logic [7:0] ev_f;

    always_comb begin
        ev_a = 8'h00;
        ev_b = 8'h00;
        ev_f = 8'h00;
        // no edges are taken before both samples are real
        if (st_reg.fill == FILL_DONE) begin
            ev_a[A_CONV_DONE_BIT] = conversion_done_event;
            ev_a[A_INPUT_CURRENT_BIT] = input_current_limit_event;
            ev_a[A_INPUT_VOLTAGE_BIT] = input_voltage_limit_event;
            ev_a[A_DIE_TEMP_BIT] = die_temp_regulation_event;
            ev_a[A_WATCHDOG_BIT] = watchdog_expiry_event;
            ev_a[A_CHARGE_STATE_BIT] = charge_state_event;

            ev_b[B_POWER_GOOD_BIT] = power_good_event;
            ev_b[B_SOURCE_BIT] = input_source_change_event;
            ev_b[B_THERMISTOR_BIT] = thermistor_zone_event;
            ev_b[B_OPTIMIZER_BIT] = current_optimizer_event;
            ev_b[B_MIN_SYS_BIT] = min_system_voltage_event;

            ev_f[F_INPUT_OV_BIT] = input_overvoltage_event;
            ev_f[F_THERMAL_BIT] = thermal_shutdown_event;
            ev_f[F_BATTERY_OV_BIT] = battery_overvoltage_event;
            ev_f[F_TIMER_BIT] = safety_timer_event;
            ev_f[F_OVERLOAD_BIT] = system_overload_event;
            ev_f[F_REVERSE_BIT] = reverse_buck_fault_event;
        end
    end

    // reads of each flag register, which clear it afterwards
    logic rd_a;
    logic rd_b;
    logic rd_f;
    assign rd_a = reg_rd && (reg_addr == FLAGS_A_OFFSET);
    assign rd_b = reg_rd && (reg_addr == FLAGS_B_OFFSET);
    assign rd_f = reg_rd && (reg_addr == FAULT_FLAGS_OFFSET);

    // conversion-complete bit hidden on the way out while running continuously
    logic [7:0] a_view;
    assign a_view = st_reg.flags_a & ~({7'h00, s_cont} << A_CONV_DONE_BIT);

    // read data for the addressed register, reserved bits forced low
    logic [7:0] read_view;
    always_comb begin
        case (reg_addr)
            FLAGS_A_OFFSET: begin
                read_view = a_view & FLAGS_A_USED;
            end
            FLAGS_B_OFFSET: begin
                read_view = st_reg.flags_b & FLAGS_B_USED;
            end
            FAULT_FLAGS_OFFSET: begin
                read_view = st_reg.flags_f & FAULT_FLAGS_USED;
            end
            default: begin
                // an address outside the three flag registers reads zero
                read_view = 8'h00;
            end
        endcase
    end

    // unmasked events that ask for an interrupt pulse
    logic [7:0] pend_a;
    logic [7:0] pend_b;
    logic [7:0] pend_f;
    assign pend_a = ev_a & ~mask_a;
    assign pend_b = ev_b & ~mask_b;
    assign pend_f = ev_f & ~mask_f;

    always_comb begin
        st_next = st_reg;
        // the synchroniser and the edge pipeline advance on every edge
        st_next.sync1 = raw;
        st_next.sync2 = st_reg.sync1;
        st_next.prev = st_reg.sync2;
        // count the edges until sync2 and prev both hold real samples
        if (st_reg.fill != FILL_DONE) begin
            st_next.fill = st_reg.fill + 2'h1;
        end
        // read returns the flags, then clears them; a new event in the same cycle survives
        st_next.flags_a = (rd_a ? 8'h00 : st_reg.flags_a) | (ev_a & FLAGS_A_USED);
        st_next.flags_b = (rd_b ? 8'h00 : st_reg.flags_b) | (ev_b & FLAGS_B_USED);
        st_next.flags_f = (rd_f ? 8'h00 : st_reg.flags_f) | (ev_f & FAULT_FLAGS_USED);
        // continuous mode keeps the conversion-complete bit at zero
        if (s_cont) begin
            st_next.flags_a[A_CONV_DONE_BIT] = 1'b0;
        end
        // read data stands until the next read
        if (reg_rd) begin
            st_next.rdata = read_view;
        end
        // reg_wr and reg_wdata are ignored: the flags are read-only
        st_next.irq = |{pend_a, pend_b, pend_f};
        if (reg_reset_cmd) begin
            st_next.flags_a = FLAGS_RESET;
            st_next.flags_b = FLAGS_RESET;
            st_next.flags_f = FLAGS_RESET;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // both outputs come straight from flops
    assign reg_rdata = st_reg.rdata;
    assign int_pulse = st_reg.irq;

endmodule

// >>> tb/cefr_flags_props.sv
// checker for the charger event flag registers
`timescale 1ns/1ps
module cefr_flags_props
    import cefr_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] mask_a,
    input wire logic [7:0] mask_b,
    input wire logic [7:0] mask_f,
    input wire logic conv_continuous,
    input wire logic input_current_regulation,
    input wire logic [2:0] charge_state,
    input wire logic power_good,
    input wire logic int_pulse
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    logic all_m;
    logic rd_a;
    assign all_m = &{mask_a, mask_b, mask_f};
    assign rd_a = reg_rd && reg_addr == FLAGS_A_OFFSET;
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
    a_rsvd_a_zero: assert property (rd_a |=> (reg_rdata & ~FLAGS_A_USED) == 8'h00)
        else $error("reserved bit set in a");
    a_rsvd_b_zero: assert property (reg_rd && reg_addr == FLAGS_B_OFFSET
        |=> (reg_rdata & ~FLAGS_B_USED) == 8'h00) else $error("reserved bit set in b");
    a_rsvd_f_zero: assert property (reg_rd && reg_addr == FAULT_FLAGS_OFFSET
        |=> (reg_rdata & ~FAULT_FLAGS_USED) == 8'h00) else $error("reserved bit set in f");
    a_cont_reads_zero: assert property (conv_continuous[*4] ##0 rd_a |=> !reg_rdata[7])
        else $error("conversion bit set in continuous mode");
    a_current_pulse: assert property ($rose(input_current_regulation) && !mask_a[6]
        |-> ##[2:4] int_pulse) else $error("no pulse on current regulation");
    a_charge_pulse: assert property ($changed(charge_state) && !mask_a[0]
        |-> ##[2:4] int_pulse) else $error("no pulse on charge state change");
    a_good_pulse: assert property ($changed(power_good) && !mask_b[7]
        |-> ##[2:4] int_pulse) else $error("no pulse on power good toggle");
    a_masked_quiet: assert property (all_m[*5] |-> !int_pulse) else $error("masked pulse");
    cover property (int_pulse);
    cover property (rd_a ##1 reg_rdata != 8'h00);
    cover property (all_m ##0 $changed(power_good));
endmodule
bind cefr_flags cefr_flags_props u_cefr_flags_props (.clock(clock), .rstn(rstn),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mask_a(mask_a),
    .mask_b(mask_b), .mask_f(mask_f), .conv_continuous(conv_continuous),
    .input_current_regulation(input_current_regulation), .charge_state(charge_state),
    .power_good(power_good), .int_pulse(int_pulse));

// >>> tb/cefr_host.sv
// host model issuing reads and writes on the flag register port
`timescale 1ns/1ps
module cefr_host
    import cefr_pkg::*;
(
    input wire logic clock,
    output logic [ADDR_W-1:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial begin
        {reg_addr, reg_rd, reg_wr, reg_wdata} = '0;
    end
    // released lines show the inverse of their last value
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        // read data is registered at the taking edge and stands from then on
        @(posedge clock);
        d = reg_rdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        {reg_addr, reg_wr, reg_wdata} <= {a, 1'b1, v};
        @(posedge clock);
        {reg_addr, reg_wr, reg_wdata} <= {~a, 1'b0, ~v};
    endtask
endmodule

// >>> tb/test_charger_event_flag_registers.sv
// testbench for the charger event flag registers
`timescale 1ns/1ps
module test_charger_event_flag_registers;
    import cefr_pkg::*;
    localparam logic [7:0] RA = FLAGS_A_OFFSET;
    localparam logic [7:0] RB = FLAGS_B_OFFSET;
    localparam logic [7:0] RF = FAULT_FLAGS_OFFSET;
    logic clock, rstn, reg_reset_cmd, conv_continuous, reg_rd, reg_wr, int_pulse;
    logic [7:0] mask_a, mask_b, mask_f, reg_wdata, reg_rdata, reg_addr;
    logic [23:0] st;
    int n_errors = 0;
    int checks = 0;
    int npulse = 0;
    cefr_host u_cefr_host (.clock(clock), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    cefr_flags u_cefr_flags (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_reset_cmd(reg_reset_cmd), .mask_a(mask_a), .mask_b(mask_b), .mask_f(mask_f),
        .conv_done(st[0]), .conv_continuous(conv_continuous),
        .input_current_regulation(st[1]), .input_voltage_regulation(st[2]),
        .die_temp_regulation(st[3]), .watchdog_expired_status(st[4]), .charge_state(st[7:5]),
        .power_good(st[8]), .input_source_type(st[11:9]), .thermistor_zone(st[14:12]),
        .current_optimizer_state(st[16:15]), .min_system_voltage(st[17]),
        .input_overvoltage(st[18]), .thermal_shutdown(st[19]), .battery_overvoltage(st[20]),
        .safety_timer_expired(st[21]), .system_overload(st[22]), .reverse_buck_fault(st[23]),
        .int_pulse(int_pulse));
    always @(posedge clock) npulse <= npulse + int'(int_pulse === 1'b1);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // toggle one status input, then read the flag twice
    task automatic flip(input int b, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        int p;
        p = npulse;
        @(posedge clock);
        st[b] <= ~st[b];
        repeat (7) @(posedge clock);
        chk(8'(npulse - p), {7'h00, e != 8'h00 && (mask_a | mask_b | mask_f) == 8'h00});
        u_cefr_host.rd(a, d);
        chk(d, e);
        u_cefr_host.rd(a, d);
        chk(d, 8'h00);
    endtask
    task automatic ev(input int b, input logic [7:0] a, input logic [7:0] e, input logic [7:0] f);
        flip(b, a, e);
        flip(b, a, f);
    endtask
    task automatic t_idle;
        logic [7:0] d;
        u_cefr_host.wr(RA, 8'hff);
        for (int a = 8'h0f; a <= 8'h12; a++) begin
            u_cefr_host.rd(8'(a), d);
            chk(d, FLAGS_RESET);
        end
        $display("idle test done");
    endtask
    task automatic t_events;
        ev(0, RA, 8'h80, 8'h00);
        ev(1, RA, 8'h40, 8'h00);
        ev(2, RA, 8'h20, 8'h00);
        ev(3, RA, 8'h10, 8'h00);
        ev(4, RA, 8'h08, 8'h00);
        ev(5, RA, 8'h01, 8'h01);
        ev(8, RB, 8'h80, 8'h80);
        ev(9, RB, 8'h10, 8'h10);
        ev(12, RB, 8'h04, 8'h04);
        ev(15, RB, 8'h02, 8'h02);
        ev(17, RB, 8'h01, 8'h01);
        ev(18, RF, 8'h80, 8'h00);
        ev(19, RF, 8'h40, 8'h00);
        ev(20, RF, 8'h20, 8'h00);
        ev(21, RF, 8'h10, 8'h00);
        ev(22, RF, 8'h08, 8'h00);
        ev(23, RF, 8'h01, 8'h00);
        $display("event test done");
    endtask
    task automatic t_modes;
        logic [7:0] d;
        {mask_a, mask_b, mask_f} <= '1;
        ev(1, RA, 8'h40, 8'h00);
        ev(8, RB, 8'h80, 8'h80);
        {mask_a, mask_b, mask_f, conv_continuous} <= {24'h000000, 1'b1};
        ev(0, RA, 8'h00, 8'h00);
        conv_continuous <= 1'b0;
        st[1] <= 1'b1;
        repeat (7) @(posedge clock);
        st[4] <= 1'b1;
        repeat (7) @(posedge clock);
        u_cefr_host.wr(RA, 8'h00);
        u_cefr_host.rd(RA, d);
        chk(d, 8'h48);
        @(posedge clock);
        st[2] <= 1'b1;
        st[8] <= 1'b1;
        st[18] <= 1'b1;
        repeat (7) @(posedge clock);
        reg_reset_cmd <= 1'b1;
        @(posedge clock);
        reg_reset_cmd <= 1'b0;
        u_cefr_host.rd(RA, d);
        chk(d, 8'h00);
        u_cefr_host.rd(RB, d);
        chk(d, 8'h00);
        u_cefr_host.rd(RF, d);
        chk(d, 8'h00);
        $display("mode test done");
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        #50000;
        n_errors++;
        summarize;
    end
    initial begin
        {rstn, reg_reset_cmd, conv_continuous, mask_a, mask_b, mask_f, st} = '0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        t_idle;
        t_events;
        t_modes;
        summarize;
    end
endmodule
